// *** dua_anc_ctrl.sv ***
// Overview of operation
// R1 - With bus isolation high during sleep, host bus activity never reaches the core strobes.
// R2 - With pump autosleep high while the oscillator is stopped in partial sleep, the charge pump is turned off.
// R3 - Bus style select high means separate read/write strobes, low means one read/write direction line.
// R4 - The reset input is active high in strobe style and active low in direction style.
// R5 - A reset held active at least 40 ns clears all registers and drives every output to its default; here only the tx, rx and pump registers are reset.
// R6 - While reset is active the transmit outputs stay high and the receive input is ignored.
// R7 - Channel B receives from the logic-level pin when the source select is high, else from the line-level pin.
// R8 - Rate select high allows up to 1 Mbps, low caps the serial rate at 250 Kbps.
// R9 - A buffered copy of the reference clock is driven on the clock output.
// R10 - The host uses chip select with read and write strobes, or chip select with a direction line.
// R11 - Host read and write cycles complete from chip select and strobes alone, with no clock needed.
// R12 - Reset release and the receive-source and rate selects are synchronised before clocked logic uses them.
`timescale 1ns/10ps
`default_nettype none
`include "dua_map.svh"

module dua_anc_ctrl
  import dua_pkg::*;
#(
  parameter int MIN_BIT_W = 10
) (
  // clock, reset, enable
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 ce,
  // mode straps
  input  wire logic                 bus_style_sel,
  input  wire logic                 dev_reset_in,
  input  wire logic                 rate_fast_sel,
  // power control
  input  wire logic                 bus_isolate_in,
  input  wire logic                 pump_autosleep_in,
  input  wire logic                 sleep_active,
  input  wire logic                 osc_stopped,
  output logic                      pump_off,
  // host bus pins
  input  wire logic                 cs_n,
  input  wire logic                 rd_strobe_n,
  input  wire logic                 wr_strobe_n,
  input  wire logic                 rw_dir,
  // strobes into the register core
  output logic                      core_rd,
  output logic                      core_wr,
  output logic                      core_reset,
  // serial pins and core side
  input  wire logic                 core_tx_a,
  input  wire logic                 core_tx_b,
  output logic                      tx_a_out,
  output logic                      tx_b_out,
  input  wire logic                 rx_src_sel_b,
  input  wire logic                 logic_level_rx_b,
  input  wire logic                 line_level_rx_b,
  output logic                      rx_b_to_core,
  // rate ceiling
  input  wire logic [MIN_BIT_W-1:0] req_bit_cyc,
  output logic [MIN_BIT_W-1:0]      min_bit_cyc,
  output logic                      rate_ok,
  // reference clock
  input  wire logic                 ref_clk_in,
  output logic                      ref_clk_buf_out
);

  localparam int RST_MIN_CYC = `DUA_RST_MIN_CYC;

  // reset polarity follows bus style
  function automatic logic reset_active(input logic style, input logic pin);
    reset_active = (style == DUA_STYLE_STROBE) ? pin : !pin; // R4
  endfunction

  // access decode per bus style; is_wr selects read or write
  function automatic logic bus_access(input logic style, input logic csn, input logic rdn,
                                      input logic wrn, input logic rw, input logic is_wr);
    if (style == DUA_STYLE_STROBE) begin
      bus_access = !csn && (is_wr ? !wrn : !rdn); // R3 R10
    end else begin
      bus_access = !csn && (is_wr ? !rw : rw); // R3 R10
    end
  endfunction

  // synchronised straps
  logic       ext_act_s;
  logic [1:0] sel_s;
  logic       rx_sel_s;
  logic       fast_s;

  // reset polarity applied before the synchroniser so one path covers both styles
  dua_sync #(.W(3)) u_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .ce       (ce),
    .async_in ({reset_active(bus_style_sel, dev_reset_in), rx_src_sel_b, rate_fast_sel}),
    .sync_out ({ext_act_s, sel_s})
  ); // R12

  assign rx_sel_s = sel_s[1];
  assign fast_s   = sel_s[0];

  // bus path: purely combinational so no clock is needed for a host cycle
  logic bus_iso;
  assign bus_iso = bus_isolate_in && sleep_active; // R1
  assign core_rd = !bus_iso && bus_access(bus_style_sel, cs_n, rd_strobe_n, wr_strobe_n, rw_dir, 1'b0); // R1 R11
  assign core_wr = !bus_iso && bus_access(bus_style_sel, cs_n, rd_strobe_n, wr_strobe_n, rw_dir, 1'b1); // R1 R11

  // reset qualifier
  dua_rst_state_type rs_q;
  dua_rst_state_type rs_d;
  logic [3:0]        rcnt_q;
  logic [3:0]        rcnt_d;

  always_comb begin
    rs_d   = rs_q;
    rcnt_d = rcnt_q;
    if (!rst_n) begin
      rs_d   = DUA_RS_HOLD;
      rcnt_d = 4'h0;
    end else if (ce) begin
      unique case (rs_q)
        DUA_RS_IDLE: begin
          if (ext_act_s) begin
            rs_d   = (RST_MIN_CYC <= 1) ? DUA_RS_HOLD : DUA_RS_QUAL;
            rcnt_d = 4'h1;
          end
        end
        DUA_RS_QUAL: begin
          // a glitch shorter than the minimum width is discarded
          if (!ext_act_s) begin
            rs_d = DUA_RS_IDLE;
          end else if (rcnt_q + 4'h1 == 4'(RST_MIN_CYC)) begin
            rs_d = DUA_RS_HOLD; // R5
          end else begin
            rcnt_d = rcnt_q + 4'h1;
          end
        end
        DUA_RS_HOLD: begin
          // release only once the synchronised level drops
          if (!ext_act_s) begin
            rs_d = DUA_RS_IDLE; // R12
          end
        end
        default: rs_d = DUA_RS_HOLD;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    rs_q   <= rs_d;
    rcnt_q <= rcnt_d;
  end

  assign core_reset = (rs_q == DUA_RS_HOLD); // R5

  // serial pins, power and rate registers
  logic                 tx_a_q;
  logic                 tx_a_d;
  logic                 tx_b_q;
  logic                 tx_b_d;
  logic                 rx_b_q;
  logic                 rx_b_d;
  logic                 pump_q;
  logic                 pump_d;
  logic                 clkb_q;
  logic                 clkb_d;
  logic [MIN_BIT_W-1:0] minb_q;
  logic [MIN_BIT_W-1:0] minb_d;

  always_comb begin
    tx_a_d = tx_a_q;
    tx_b_d = tx_b_q;
    rx_b_d = rx_b_q;
    pump_d = pump_q;
    clkb_d = clkb_q;
    minb_d = minb_q;
    if (!rst_n) begin
      tx_a_d = `DUA_TX_IDLE;
      tx_b_d = `DUA_TX_IDLE;
      rx_b_d = `DUA_RX_IDLE;
      pump_d = `DUA_PUMP_OFF_RST;
      clkb_d = 1'b0;
      minb_d = MIN_BIT_W'(`DUA_MIN_BIT_SLOW);
    end else if (ce) begin
      tx_a_d = core_reset ? `DUA_TX_IDLE : core_tx_a; // R6
      tx_b_d = core_reset ? `DUA_TX_IDLE : core_tx_b; // R6
      if (core_reset) begin
        rx_b_d = `DUA_RX_IDLE; // R6
      end else begin
        rx_b_d = rx_sel_s ? logic_level_rx_b : line_level_rx_b; // R7
      end
      // pump may only drop once the oscillator is already stopped
      pump_d = !core_reset && pump_autosleep_in && sleep_active && osc_stopped; // R2
      clkb_d = ref_clk_in; // R9
      minb_d = fast_s ? MIN_BIT_W'(`DUA_MIN_BIT_FAST) : MIN_BIT_W'(`DUA_MIN_BIT_SLOW); // R8
    end
  end

  always_ff @(posedge clk) begin
    tx_a_q <= tx_a_d;
    tx_b_q <= tx_b_d;
    rx_b_q <= rx_b_d;
    pump_q <= pump_d;
    clkb_q <= clkb_d;
    minb_q <= minb_d;
  end

  assign tx_a_out        = tx_a_q;
  assign tx_b_out        = tx_b_q;
  assign rx_b_to_core    = rx_b_q;
  assign pump_off        = pump_q;
  assign ref_clk_buf_out = clkb_q;
  assign min_bit_cyc     = minb_q;
  // a shorter bit time than the ceiling allows is flagged, not clamped
  assign rate_ok         = (req_bit_cyc >= minb_q); // R8

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_tx_held_high: assert property (ce && core_reset |=> tx_a_out && tx_b_out) // R6
    else $error("transmit output not high during reset");

  chk_rx_ignored: assert property (ce && core_reset |=> rx_b_to_core == `DUA_RX_IDLE) // R6
    else $error("receive input not ignored during reset");

  chk_reset_width: assert property ($rose(core_reset) |-> $past(ext_act_s, 1) && $past(ext_act_s, 4)) // R5
    else $error("core reset entered without minimum width");

  chk_short_pulse: assert property (ce && !core_reset && $rose(ext_act_s) ##1 ce && !ext_act_s |=> !core_reset) // R5
    else $error("short reset pulse was accepted");

  chk_bus_isolated: assert property (bus_isolate_in && sleep_active |-> !core_rd && !core_wr) // R1
    else $error("host strobe passed while isolated");

  chk_pump_off_sleep: assert property (ce && !core_reset && pump_autosleep_in && sleep_active && osc_stopped
                                       |=> pump_off) // R2
    else $error("charge pump not turned off in partial sleep");

  chk_pump_on_awake: assert property (ce && !osc_stopped |=> !pump_off) // R2
    else $error("charge pump off while oscillator runs");

  chk_rx_source_sel: assert property (ce && !core_reset && rx_sel_s |=> rx_b_to_core == $past(logic_level_rx_b)) // R7
    else $error("wrong channel B receive source");

  chk_rate_ceiling: assert property (ce && !fast_s |=> min_bit_cyc == MIN_BIT_W'(`DUA_MIN_BIT_SLOW)) // R8
    else $error("slow rate ceiling not applied");

  chk_clk_buffered: assert property (ce |=> ref_clk_buf_out == $past(ref_clk_in)) // R9
    else $error("reference clock copy wrong");

  chk_strobe_write: assert property (bus_style_sel && !cs_n && !wr_strobe_n && !(bus_isolate_in && sleep_active)
                                     |-> core_wr && !core_rd) // R3
    else $error("strobe style write not decoded");

  cov_reset_taken: cover property ($rose(core_reset));
  cov_pump_off:    cover property ($rose(pump_off));
  cov_dir_read:    cover property (!bus_style_sel && core_rd);
  cov_fast_rate:   cover property (min_bit_cyc == MIN_BIT_W'(`DUA_MIN_BIT_FAST));

endmodule

`default_nettype wire

// *** dua_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none

module dua_host_model (
  // clock and bus style
  input  wire logic clk,
  input  wire logic style,
  // host pins
  output logic      cs_n,
  output logic      rd_strobe_n,
  output logic      wr_strobe_n,
  output logic      rw_dir
);
  initial begin
    cs_n = 1'h1;
    rd_strobe_n = 1'h1;
    wr_strobe_n = 1'h1;
    rw_dir = 1'h0;
  end

  // pins change just after an edge and hold until stop
  task automatic start(input logic wr);
    @(posedge clk);
    cs_n <= 1'h0;
    if (style) begin
      rd_strobe_n <= wr;
      wr_strobe_n <= !wr;
    end else begin
      rw_dir <= !wr;
    end
  endtask

  // direction line has no pull, so it flips once released
  task automatic stop;
    @(posedge clk);
    cs_n <= 1'h1;
    rd_strobe_n <= 1'h1;
    wr_strobe_n <= 1'h1;
    rw_dir <= ~rw_dir;
  endtask
endmodule

`default_nettype wire

// *** dua_map.svh ***
`ifndef DUA_MAP_SVH
`define DUA_MAP_SVH

// clock
`define DUA_CLK_HZ          100000000
`define DUA_CLK_PERIOD_NS   10

// external reset qualification
`define DUA_RST_MIN_NS      40
`define DUA_RST_MIN_CYC     ((`DUA_RST_MIN_NS + `DUA_CLK_PERIOD_NS - 1) / `DUA_CLK_PERIOD_NS)

// serial rate ceilings
`define DUA_RATE_FAST_BPS   1000000
`define DUA_RATE_SLOW_BPS   250000
`define DUA_MIN_BIT_FAST    (`DUA_CLK_HZ / `DUA_RATE_FAST_BPS)
`define DUA_MIN_BIT_SLOW    (`DUA_CLK_HZ / `DUA_RATE_SLOW_BPS)

// reset values
`define DUA_TX_IDLE         1'h1
`define DUA_RX_IDLE         1'h1
`define DUA_PUMP_OFF_RST    1'h0

`endif

// *** dua_pkg.sv ***
package dua_pkg;

  typedef enum logic {
    DUA_STYLE_DIR    = 1'b0,
    DUA_STYLE_STROBE = 1'b1
  } dua_style_type;

  typedef enum logic [1:0] {
    DUA_RS_IDLE,
    DUA_RS_QUAL,
    DUA_RS_HOLD
  } dua_rst_state_type;

endpackage

// *** dua_sync.sv ***
`timescale 1ns/10ps
`default_nettype none

module dua_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  // level in and synchronised level out
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  always_comb begin
    meta_d = meta_q;
    sync_d = sync_q;
    if (!rst_n) begin
      meta_d = '0;
      sync_d = '0;
    end else if (ce) begin
      meta_d = async_in;
      sync_d = meta_q;
    end
  end

  always_ff @(posedge clk) begin
    meta_q <= meta_d;
    sync_q <= sync_d;
  end

  assign sync_out = sync_q;

endmodule

`default_nettype wire

// *** dual_uart_ancillary_pin_control_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "dua_map.svh"

module dual_uart_ancillary_pin_control_tb;
  logic       clk = 1'h0, rst_n = 1'h0, ce = 1'h1, style = 1'h1, dev_rst = 1'h0, fast = 1'h0;
  logic       iso = 1'h0, pump_as = 1'h0, sleep = 1'h0, osc_stop = 1'h0, pump_off;
  logic       cs_n, rd_n, wr_n, rw_dir, core_rd, core_wr, core_reset;
  logic       tx_a = 1'h0, tx_b = 1'h0, tx_a_out, tx_b_out;
  logic       rx_sel = 1'h0, rx_logic = 1'h0, rx_line = 1'h0, rx_core;
  logic [9:0] req = 10'h000, min_bit;
  logic       rate_ok, ref_in = 1'h0, ref_out;
  int         failures = 0, checks = 0;

  always #5 clk = ~clk;

  dua_host_model u_dua_host_model (.clk(clk), .style(style), .cs_n(cs_n), .rd_strobe_n(rd_n),
                                   .wr_strobe_n(wr_n), .rw_dir(rw_dir));

  dua_anc_ctrl u_dua_anc_ctrl (.clk(clk), .rst_n(rst_n), .ce(ce), .bus_style_sel(style),
    .dev_reset_in(dev_rst), .rate_fast_sel(fast), .bus_isolate_in(iso), .pump_autosleep_in(pump_as),
    .sleep_active(sleep), .osc_stopped(osc_stop), .pump_off(pump_off), .cs_n(cs_n),
    .rd_strobe_n(rd_n), .wr_strobe_n(wr_n), .rw_dir(rw_dir), .core_rd(core_rd), .core_wr(core_wr),
    .core_reset(core_reset), .core_tx_a(tx_a), .core_tx_b(tx_b), .tx_a_out(tx_a_out),
    .tx_b_out(tx_b_out), .rx_src_sel_b(rx_sel), .logic_level_rx_b(rx_logic),
    .line_level_rx_b(rx_line), .rx_b_to_core(rx_core), .req_bit_cyc(req), .min_bit_cyc(min_bit),
    .rate_ok(rate_ok), .ref_clk_in(ref_in), .ref_clk_buf_out(ref_out));

  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic finish_test;
    if (failures == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // reset pin polarity, minimum width and output defaults
  task automatic test_reset;
    for (int s = 0; s < 2; s++) begin
      @(posedge clk);
      style <= s[0];
      dev_rst <= !s[0];
      step(8);
      dev_rst <= s[0];
      step(2);
      dev_rst <= !s[0];
      step(3);
      // single-cycle glitch must be dropped as well
      dev_rst <= s[0];
      step(1);
      dev_rst <= !s[0];
      for (int i = 0; i < 10; i++) begin
        step(1);
        chk(core_reset, 1'h0);
      end
      dev_rst <= s[0];
      step(12);
      chk(core_reset, 1'h1);
      chk(tx_a_out, 1'h1);
      chk(tx_b_out, 1'h1);
      chk(rx_core, 1'h1);
      chk(pump_off, 1'h0);
      dev_rst <= !s[0];
      step(8);
      chk(core_reset, 1'h0);
      chk(tx_a_out, 1'h0);
      chk(tx_b_out, 1'h0);
    end
  endtask

  // both bus styles, with and without isolation, clock enable off
  task automatic test_bus;
    ce <= 1'h0;
    sleep <= 1'h1;
    for (int s = 0; s < 4; s++) begin
      style <= s[0];
      dev_rst <= !s[0];
      iso <= s[1];
      for (int w = 0; w < 2; w++) begin
        u_dua_host_model.start(w[0]);
        step(1);
        chk(core_wr, w[0] & !s[1]);
        chk(core_rd, !w[0] & !s[1]);
        u_dua_host_model.stop();
        step(1);
        chk(core_wr | core_rd, 1'h0);
      end
    end
    ce <= 1'h1;
    iso <= 1'h0;
    sleep <= 1'h0;
  endtask

  // pump, receive source, rate ceiling and clock copy
  task automatic test_misc;
    // let the bus test's last drives take effect first
    step(1);
    sleep <= 1'h1;
    osc_stop <= 1'h1;
    pump_as <= 1'h1;
    step(5);
    chk(pump_off, 1'h1);
    pump_as <= 1'h0;
    step(5);
    chk(pump_off, 1'h0);
    for (int s = 0; s < 2; s++) begin
      rx_sel <= s[0];
      rx_logic <= s[0];
      rx_line <= !s[0];
      fast <= s[0];
      step(6);
      // only the selected pin carries the high level
      chk(rx_core, 1'h1);
      chk(min_bit, s[0] ? 10'(`DUA_MIN_BIT_FAST) : 10'(`DUA_MIN_BIT_SLOW));
      req <= min_bit;
      step(1);
      chk(rate_ok, 1'h1);
      req <= min_bit - 10'h001;
      step(1);
      chk(rate_ok, 1'h0);
    end
    for (int i = 0; i < 4; i++) begin
      ref_in <= i[0];
      step(2);
      chk(ref_out, i[0]);
    end
  endtask

  initial begin
    step(12);
    rst_n <= 1'h1;
    step(6);
    test_reset();
    test_bus();
    test_misc();
    finish_test();
  end

  // all scenarios finish in well under a thousand cycles
  initial begin
    #20000;
    failures++;
    finish_test();
  end
endmodule

`default_nettype wire
